//--- logic/ssc_cfg.svh
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH

// Core clock and derived timing
`define SSC_CLK_NS         20
`define SSC_CLK_KHZ        16'd50000
`define SSC_CLK_HALF_KHZ   16'd25000
`define SSC_SETTLE_NS      2000
`define SSC_SETTLE_CYC     ((`SSC_SETTLE_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS)
`define SSC_SYNC_LOSS_NS   10000
`define SSC_SYNC_LOSS_CYC  (`SSC_SYNC_LOSS_NS / `SSC_CLK_NS)
`define SSC_FREQ_STEP_KHZ  11'd50
`define SSC_FREQ_CODE_MIN  5'd6
`define SSC_FREQ_CODE_MAX  5'd30

// Register word indices; byte address is four times the index
`define SSC_OFF_MODE       6'd0
`define SSC_OFF_FREQ       6'd1
`define SSC_OFF_STATUS     6'd2
`define SSC_OFF_VOUT       6'd3
`define SSC_OFF_VLAST      6'd11

// Limit percentages of the voltage target
`define SSC_PCT_TARGET     7'd100
`define SSC_PCT_PG_ON      7'd90
`define SSC_PCT_PG_OFF     7'd85
`define SSC_PCT_OV_FAULT   7'd115
`define SSC_PCT_OV_WARN    7'd110
`define SSC_PCT_UV_WARN    7'd90
`define SSC_PCT_UV_FAULT   7'd80
`define SSC_PCT_MRG_LOW    7'd95
`define SSC_PCT_MRG_HIGH   7'd105

// Bus responses
`define SSC_RESP_OKAY      2'b00
`define SSC_RESP_SLVERR    2'b10

`endif

//--- logic/ssc_pkg.sv
package ssc_pkg;

  // Power-up sequencer states
  typedef enum logic [3:0] {
    SSC_ST_RESET = 4'b0001,
    SSC_ST_SENSE = 4'b0010,
    SSC_ST_LATCH = 4'b0100,
    SSC_ST_RUN   = 4'b1000
  } ssc_state_t;

  // Switching configuration codes
  typedef enum logic [15:0] {
    SSC_STANDALONE = 16'h0000,
    SSC_MASTER     = 16'h0100,
    SSC_SLAVE_IN   = 16'h0120,
    SSC_SLAVE_OUT  = 16'h0121
  } ssc_mode_t;

endpackage : ssc_pkg

//--- logic/ssc_switch_ctrl.sv
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "ssc_cfg.svh"
module ssc_switch_ctrl
  import ssc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        syncClk,
  input  wire logic [3:0]  vsetStrapCode,
  input  wire logic [3:0]  freqStrapCode,
  output logic             senseCurrentEn,
  output logic             freqSyncPinOut,
  output logic             freqSyncPinOe,
  output logic             swNode,
  output logic             strapDone,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam logic [7:0]  SETTLE_CYC = 8'(`SSC_SETTLE_CYC);
  localparam logic [15:0] LOSS_CYC   = 16'(`SSC_SYNC_LOSS_CYC);

  // Target voltage in 1/512 V steps
  function automatic logic [15:0] voutOf(input logic [3:0] i);
    unique case (i)
      4'h0:    voutOf = 16'd307;
      4'h1:    voutOf = 16'd461;
      4'h2:    voutOf = 16'd486;
      4'h3:    voutOf = 16'd512;
      4'h4:    voutOf = 16'd538;
      4'h5:    voutOf = 16'd614;
      4'h6:    voutOf = 16'd640;
      4'h7:    voutOf = 16'd768;
      4'h8:    voutOf = 16'd922;
      4'h9:    voutOf = 16'd1075;
      4'ha:    voutOf = 16'd1280;
      4'hb:    voutOf = 16'd1690;
      4'hc:    voutOf = 16'd2560;
      default: voutOf = 16'd6144;
    endcase
  endfunction : voutOf

  // Default switching frequency in kHz
  function automatic logic [10:0] khzOf(input logic [3:0] i);
    unique case (i)
      4'h0:    khzOf = 11'd300;
      4'h1:    khzOf = 11'd400;
      4'h2:    khzOf = 11'd500;
      4'h3:    khzOf = 11'd550;
      4'h4:    khzOf = 11'd600;
      4'h5:    khzOf = 11'd650;
      4'h6:    khzOf = 11'd700;
      4'h7:    khzOf = 11'd750;
      4'h8:    khzOf = 11'd800;
      4'h9:    khzOf = 11'd850;
      4'ha:    khzOf = 11'd900;
      4'hb:    khzOf = 11'd950;
      4'hc:    khzOf = 11'd1000;
      4'hd:    khzOf = 11'd1250;
      default: khzOf = 11'd1500;
    endcase
  endfunction : khzOf

  // Percentage for each voltage register slot
  function automatic logic [6:0] pctOf(input logic [3:0] i);
    unique case (i)
      4'h1:    pctOf = `SSC_PCT_PG_ON;
      4'h2:    pctOf = `SSC_PCT_PG_OFF;
      4'h3:    pctOf = `SSC_PCT_OV_FAULT;
      4'h4:    pctOf = `SSC_PCT_OV_WARN;
      4'h5:    pctOf = `SSC_PCT_UV_WARN;
      4'h6:    pctOf = `SSC_PCT_UV_FAULT;
      4'h7:    pctOf = `SSC_PCT_MRG_LOW;
      4'h8:    pctOf = `SSC_PCT_MRG_HIGH;
      default: pctOf = `SSC_PCT_TARGET;
    endcase
  endfunction : pctOf

  // Percentage of a target, truncated
  function automatic logic [15:0] limitOf(input logic [15:0] tgt, input logic [6:0] pct);
    logic [22:0] prod;
    prod    = tgt * pct;
    limitOf = 16'(prod / 23'd100);
  endfunction : limitOf

  // Byte-lane merge of the low half-word
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  ssc_state_t  state_r, state_nxt;
  logic [7:0]  settleCnt_r;
  logic [3:0]  vIdx_r, fIdx_r;
  ssc_mode_t   mode_r;
  logic [4:0]  freqCode_r;
  logic [15:0] vreg_r [0:8];
  logic [15:0] acc_r, accSum, acc_nxt;
  logic [15:0] periodCnt_r, periodCnt_nxt, period_r;
  logic        extPresent_r, extPresent_nxt;
  logic        swNode_r, swNode_nxt, pinOut_r, pinOe_r, sense_r;
  logic        edgeSeen, running, latching, isMaster, isSlave, outPh, useExt;
  logic        ownHigh, extHigh;
  logic [10:0] ownInc;

  // Link-side edge capture into the core domain
  ssc_sync_cross uCross (
    .syncClk  (syncClk),
    .clock    (clock),
    .rst      (rst),
    .edgeSeen (edgeSeen)
  );

  // Power-up sequencer: sense, latch straps once, then run
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SSC_ST_RESET: state_nxt = SSC_ST_SENSE;
      SSC_ST_SENSE: if (settleCnt_r == SETTLE_CYC) state_nxt = SSC_ST_LATCH;
      SSC_ST_LATCH: state_nxt = SSC_ST_RUN;
      SSC_ST_RUN:   state_nxt = SSC_ST_RUN;
      default:      state_nxt = SSC_ST_RESET;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r     <= SSC_ST_RESET;
      settleCnt_r <= 8'h0;
    end else begin
      state_r     <= state_nxt;
      settleCnt_r <= (state_r == SSC_ST_SENSE) ? settleCnt_r + 8'h1 : 8'h0;
    end
  end

  assign running  = (state_r == SSC_ST_RUN);
  assign latching = (state_r == SSC_ST_LATCH);

  // Strap indices captured once at the latch step
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      vIdx_r <= 4'h0;
      fIdx_r <= 4'h0;
    end else if (latching) begin
      vIdx_r <= vsetStrapCode;
      fIdx_r <= freqStrapCode;
    end
  end

  // Mode and frequency decode
  assign isMaster = (mode_r == SSC_MASTER);
  assign isSlave  = (mode_r == SSC_SLAVE_IN) || (mode_r == SSC_SLAVE_OUT);
  assign outPh    = (mode_r == SSC_SLAVE_OUT);
  assign useExt   = isSlave && extPresent_r;
  assign ownInc   = (freqCode_r != 5'h0) ? 11'(freqCode_r * `SSC_FREQ_STEP_KHZ) : khzOf(fIdx_r);

  // Own oscillator: kHz added per cycle, wrap at core rate in kHz
  assign accSum  = acc_r + {5'h0, ownInc};
  assign acc_nxt = !running ? 16'h0 : (accSum >= `SSC_CLK_KHZ) ? accSum - `SSC_CLK_KHZ : accSum;
  assign ownHigh = (acc_r < `SSC_CLK_HALF_KHZ);

  // External clock: period measure, presence and half-period phase
  assign periodCnt_nxt  = edgeSeen ? 16'h0 : (periodCnt_r < LOSS_CYC) ? periodCnt_r + 16'h1 : periodCnt_r;
  assign extPresent_nxt = edgeSeen ? (periodCnt_r < LOSS_CYC) : (periodCnt_r < LOSS_CYC) && extPresent_r;
  assign extHigh        = edgeSeen || (periodCnt_r < {1'b0, period_r[15:1]});

  // Switching node: external lock in slave mode with the external clock present, else own timing
  assign swNode_nxt = running && (useExt ? (extHigh ^ outPh) : ownHigh);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_r        <= 16'h0;
      periodCnt_r  <= LOSS_CYC;
      period_r     <= 16'h0;
      extPresent_r <= 1'b0;
    end else begin
      acc_r        <= acc_nxt;
      periodCnt_r  <= periodCnt_nxt;
      period_r     <= edgeSeen ? periodCnt_r + 16'h1 : period_r;
      extPresent_r <= extPresent_nxt;
    end
  end

  // Pin drive and node outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      swNode_r <= 1'b0;
      pinOut_r <= 1'b0;
      pinOe_r  <= 1'b0;
      sense_r  <= 1'b0;
    end else begin
      swNode_r <= swNode_nxt;
      pinOut_r <= isMaster && running && swNode_nxt;
      pinOe_r  <= isMaster && running;
      sense_r  <= (state_nxt == SSC_ST_SENSE);
    end
  end

  assign swNode         = swNode_r;
  assign freqSyncPinOut = pinOut_r;
  assign freqSyncPinOe  = pinOe_r;
  assign senseCurrentEn = sense_r;
  assign strapDone      = running;

  // Write channel: address and data taken in either order
  logic        awHeld_r, wHeld_r, bvalid_r, doWrite, wrOk;
  logic [5:0]  awIdx_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic [1:0]  bresp_r;
  logic [15:0] wrHalf;
  logic [4:0]  wrFreq;
  logic        wrMode, wrFreqOk, wrModeOk, wrVreg;
  logic [3:0]  wrSlot;

  assign s_axi_awready = !awHeld_r && !bvalid_r;
  assign s_axi_wready  = !wHeld_r && !bvalid_r;
  assign doWrite       = awHeld_r && wHeld_r && !bvalid_r;
  assign wrHalf        = merge16(16'h0, wData_r, wStrb_r);
  assign wrFreq        = wStrb_r[0] ? wData_r[4:0] : freqCode_r;
  assign wrMode        = (awIdx_r == `SSC_OFF_MODE);
  assign wrModeOk      = wrHalf inside {SSC_STANDALONE, SSC_MASTER, SSC_SLAVE_IN, SSC_SLAVE_OUT};
  assign wrFreqOk      = (wrFreq == 5'h0) || ((wrFreq >= `SSC_FREQ_CODE_MIN) && (wrFreq <= `SSC_FREQ_CODE_MAX));
  assign wrVreg        = (awIdx_r >= `SSC_OFF_VOUT) && (awIdx_r <= `SSC_OFF_VLAST);
  assign wrSlot        = awIdx_r[3:0] - 4'h3;
  assign wrOk          = (wrMode && wrModeOk) || ((awIdx_r == `SSC_OFF_FREQ) && wrFreqOk) || wrVreg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= `SSC_RESP_OKAY;
      awIdx_r  <= 6'h0;
      wData_r  <= 32'h0;
      wStrb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awIdx_r  <= s_axi_awaddr[7:2];
      end else if (doWrite) awHeld_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) wHeld_r <= 1'b0;
      if (doWrite) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wrOk ? `SSC_RESP_OKAY : `SSC_RESP_SLVERR;
      end else if (s_axi_bready) bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // Mode and frequency override registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_r     <= SSC_MASTER;
      freqCode_r <= 5'h0;
    end else begin
      if (doWrite && wrMode && wrModeOk) mode_r <= ssc_mode_t'(wrHalf);
      if (doWrite && (awIdx_r == `SSC_OFF_FREQ) && wrFreqOk) freqCode_r <= wrFreq;
    end
  end

  // Voltage target and limits: strap load, then per-word override
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 9; i++) vreg_r[i] <= 16'h0;
    end else begin
      for (int i = 0; i < 9; i++) begin
        if (latching) vreg_r[i] <= limitOf(voutOf(vsetStrapCode), pctOf(4'(i)));
        else if (doWrite && wrVreg && (wrSlot == 4'(i))) vreg_r[i] <= merge16(vreg_r[i], wData_r, wStrb_r);
      end
    end
  end

  // Read channel: registered data
  logic [5:0]  rdIdx;
  logic        rdVreg, rdMapped, rvalid_r;
  logic [3:0]  rdSlot;
  logic [31:0] statusWord, rdWord, rdata_r;
  logic [1:0]  rresp_r;

  assign s_axi_arready = !rvalid_r;
  assign rdIdx         = s_axi_araddr[7:2];
  assign rdVreg        = (rdIdx >= `SSC_OFF_VOUT) && (rdIdx <= `SSC_OFF_VLAST);
  assign rdSlot        = rdIdx[3:0] - 4'h3;
  assign rdMapped      = rdVreg || (rdIdx <= `SSC_OFF_STATUS);
  assign statusWord    = {5'h0, ownInc, 4'h0, vIdx_r, fIdx_r, 1'b0, useExt, extPresent_r, running};
  assign rdWord        = (rdIdx == `SSC_OFF_MODE)   ? {16'h0, mode_r} :
                         (rdIdx == `SSC_OFF_FREQ)   ? {27'h0, freqCode_r} :
                         (rdIdx == `SSC_OFF_STATUS) ? statusWord :
                         rdVreg                     ? {16'h0, vreg_r[rdSlot]} : 32'h0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= `SSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rdWord;
      rresp_r  <= rdMapped ? `SSC_RESP_OKAY : `SSC_RESP_SLVERR;
    end else if (s_axi_rready) rvalid_r <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_sense_power_only: assert property (running |=> !senseCurrentEn ##1 !senseCurrentEn)
    else $error("sense current after power-up");
  chk_master_pin_quiet: assert property (!running |=> !freqSyncPinOe && !freqSyncPinOut)
    else $error("sync pin driven before switching");
  chk_standalone_pin_release: assert property ((mode_r == SSC_STANDALONE) |=> !freqSyncPinOe)
    else $error("standalone mode drives sync pin");
  chk_master_pin_node: assert property (freqSyncPinOe |-> freqSyncPinOut == swNode)
    else $error("master sync output not in phase with node");
  chk_mode_default_code: assert property ($past(rst) |-> mode_r == SSC_MASTER)
    else $error("mode not master after reset");
  chk_slave_edge_phase: assert property (useExt && edgeSeen |=> swNode == !$past(outPh))
    else $error("slave node not aligned to external edge");
  chk_ext_loss_fallback: assert property ((periodCnt_r == LOSS_CYC) && !edgeSeen |=> !extPresent_r)
    else $error("external clock still marked present after loss");
  chk_limit_from_target: assert property (latching |=> vreg_r[3] == limitOf(vreg_r[0], `SSC_PCT_OV_FAULT)
                                          && vreg_r[6] == limitOf(vreg_r[0], `SSC_PCT_UV_FAULT))
    else $error("limits not derived from target");
  chk_vout_strap_load: assert property (latching |=> vreg_r[0] == voutOf($past(vsetStrapCode)))
    else $error("target not loaded from strap");
  chk_freq_strap_load: assert property (latching |=> fIdx_r == $past(freqStrapCode))
    else $error("frequency strap not captured");
  chk_freq_step_code: assert property ((freqCode_r != 5'h0) |-> ownInc == 11'(freqCode_r * `SSC_FREQ_STEP_KHZ))
    else $error("programmed frequency not in 50 kHz steps");

  cov_master_running: cover property (running && freqSyncPinOe ##1 freqSyncPinOut);
  cov_slave_in_lock: cover property (useExt && (mode_r == SSC_SLAVE_IN) && edgeSeen);
  cov_slave_out_lock: cover property (useExt && (mode_r == SSC_SLAVE_OUT) && edgeSeen);
  cov_ext_loss: cover property (extPresent_r ##1 !extPresent_r);

endmodule : ssc_switch_ctrl

//--- logic/ssc_sync_cross.sv
`timescale 1ns/1ps
module ssc_sync_cross (
  input  wire logic syncClk,
  input  wire logic clock,
  input  wire logic rst,
  output logic      edgeSeen
);

  logic       linkToggle_r;
  logic [2:0] sync_r;
  logic       accepted_r;
  logic       edgeSeen_r;
  logic       stableNew;

  // Link side flips once per rising sync edge
  always_ff @(posedge syncClk or posedge rst) begin
    if (rst) linkToggle_r <= 1'b0;
    else linkToggle_r <= ~linkToggle_r;
  end

  // Three-stage capture; a change counts when stages two and three agree
  assign stableNew = (sync_r[1] == sync_r[2]) && (sync_r[2] != accepted_r);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_r     <= 3'h0;
      accepted_r <= 1'b0;
      edgeSeen_r <= 1'b0;
    end else begin
      sync_r     <= {sync_r[1:0], linkToggle_r};
      accepted_r <= stableNew ? sync_r[2] : accepted_r;
      edgeSeen_r <= stableNew;
    end
  end

  assign edgeSeen = edgeSeen_r;

  chk_edge_single_pulse: assert property (@(posedge clock) disable iff (rst) edgeSeen_r |=> !edgeSeen_r)
    else $error("sync edge pulse longer than one cycle");

endmodule : ssc_sync_cross

//--- verif/ssc_sync_source.sv
`timescale 1ns/1ps
module ssc_sync_source (
  input  wire logic runEn,
  output logic      syncOut
);
  // Far-side sync clock, parked low between bursts
  initial begin
    syncOut = 1'b0;
    #7;
    forever begin
      #62.5;
      if (runEn) begin
        syncOut = ~syncOut;
      end else begin
        syncOut = 1'b0;
      end
    end
  end
endmodule : ssc_sync_source

//--- verif/tb.sv
`timescale 1ns/1ps
`include "ssc_cfg.svh"
`define CHK(act, exp, msg) begin checksDone++; if ((act) !== (exp)) begin errTotal++; $display("ERROR %0t ns: %s", $time, msg); end end
module tb
  import ssc_pkg::*;
();
  localparam logic [1:0]  OK = `SSC_RESP_OKAY;
  localparam logic [1:0]  SE = `SSC_RESP_SLVERR;
  localparam logic [31:0] FM = 32'hffff_ffff;
  localparam logic [31:0] SM = 32'h07ff_0ff1;
  typedef struct {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [1:0]  wr;
    logic [1:0]  rr;
    logic [31:0] exp;
    logic [31:0] msk;
  } ssc_row_t;
  logic        clock, rst, syncPin, runEn, partnerClk;
  logic [3:0]  vsetStrapCode, freqStrapCode, wstrb;
  logic        senseCurrentEn, freqSyncPinOut, freqSyncPinOe, swNode, strapDone;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          errTotal, checksDone, hi, oe, rise, diff, ph;
  // Strap-derived defaults, then mode and frequency codes, then overrides
  ssc_row_t    rows [27] = '{
    '{8'h00, 1'b0, 32'h0, OK, OK, 32'h0100, FM}, '{8'h0c, 1'b0, 32'h0, OK, OK, 32'h1800, FM},
    '{8'h10, 1'b0, 32'h0, OK, OK, 32'h1599, FM}, '{8'h14, 1'b0, 32'h0, OK, OK, 32'h1466, FM},
    '{8'h18, 1'b0, 32'h0, OK, OK, 32'h1b99, FM}, '{8'h1c, 1'b0, 32'h0, OK, OK, 32'h1a66, FM},
    '{8'h20, 1'b0, 32'h0, OK, OK, 32'h1599, FM}, '{8'h24, 1'b0, 32'h0, OK, OK, 32'h1333, FM},
    '{8'h28, 1'b0, 32'h0, OK, OK, 32'h16cc, FM}, '{8'h2c, 1'b0, 32'h0, OK, OK, 32'h1933, FM},
    '{8'h08, 1'b0, 32'h0, OK, OK, 32'h05dc_0de1, SM}, '{8'h00, 1'b1, 32'h0000, OK, OK, 32'h0000, FM},
    '{8'h00, 1'b1, 32'h0120, OK, OK, 32'h0120, FM}, '{8'h00, 1'b1, 32'h0121, OK, OK, 32'h0121, FM},
    '{8'h00, 1'b1, 32'h0101, SE, OK, 32'h0121, FM}, '{8'h00, 1'b1, 32'h0100, OK, OK, 32'h0100, FM},
    '{8'h04, 1'b0, 32'h0, OK, OK, 32'h0, FM}, '{8'h04, 1'b1, 32'h5, SE, OK, 32'h0, FM},
    '{8'h04, 1'b1, 32'h1f, SE, OK, 32'h0, FM}, '{8'h04, 1'b1, 32'h6, OK, OK, 32'h6, FM},
    '{8'h08, 1'b0, 32'h0, OK, OK, 32'h012c_0de1, SM}, '{8'h04, 1'b1, 32'h14, OK, OK, 32'h14, FM},
    '{8'h08, 1'b1, 32'h0, SE, OK, 32'h03e8_0de1, SM}, '{8'h30, 1'b1, 32'h0, SE, SE, 32'h0, FM},
    '{8'h10, 1'b1, 32'h1234, OK, OK, 32'h1234, FM}, '{8'h0c, 1'b1, 32'h0200, OK, OK, 32'h0200, FM},
    '{8'h10, 1'b0, 32'h0, OK, OK, 32'h1234, FM}};

  // Shared pin: device drives when enabled, else the far side
  assign syncPin = freqSyncPinOe ? freqSyncPinOut : partnerClk;

  ssc_switch_ctrl uut (
    .clock, .rst, .syncClk(syncPin), .vsetStrapCode, .freqStrapCode, .senseCurrentEn,
    .freqSyncPinOut, .freqSyncPinOe, .swNode, .strapDone,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  ssc_sync_source partner (.runEn, .syncOut(partnerClk));

  // Core clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ah, wh, bh;
    @(posedge clock);
    n = 0;
    bh = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh && n < 100) begin
      @(negedge clock);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      r = bresp;
      @(posedge clock);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    `CHK(bh, 1'b1, "no write answer")
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ah, rh;
    @(posedge clock);
    n = 0;
    rh = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rh && n < 100) begin
      @(negedge clock);
      ah = arvalid && arready;
      rh = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ah) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    `CHK(rh, 1'b1, "no read answer")
  endtask : axr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axr(a, rd, resp);
    `CHK(rd & m, e, "register readback")
  endtask : rdchk

  // Node rises are also tagged with the far clock level one sample earlier
  task automatic win(input int n);
    logic last, lastP;
    hi = 0;
    oe = 0;
    rise = 0;
    diff = 0;
    ph = 0;
    last = swNode;
    lastP = partnerClk;
    repeat (n) begin
      @(negedge clock);
      hi += (freqSyncPinOut === 1'b1);
      oe += (freqSyncPinOe === 1'b1);
      rise += (swNode === 1'b1 && last === 1'b0);
      ph += (swNode === 1'b1 && last === 1'b0 && lastP === 1'b1);
      diff += (freqSyncPinOut !== swNode);
      last = swNode;
      lastP = partnerClk;
    end
  endtask : win

  task automatic wait_done;
    int n, early;
    n = 0;
    early = 0;
    repeat (3) @(negedge clock);
    `CHK(senseCurrentEn, 1'b1, "sense current off during power-up")
    while (strapDone !== 1'b1 && n < 300) begin
      @(negedge clock);
      if (strapDone !== 1'b1 && freqSyncPinOe !== 1'b0) early++;
      n++;
    end
    `CHK(early, 0, "sync pin driven before switching")
    `CHK(strapDone, 1'b1, "strap sequence unfinished")
    `CHK(senseCurrentEn, 1'b0, "sense current still on")
  endtask : wait_done

  // Hang guard
  initial begin
    #400_000;
    errTotal++;
    $display("ERROR %0t ns: watchdog expired", $time);
    end_sim();
  end

  // Main sequence
  initial begin
    {rst, runEn, awvalid, wvalid, bready, arvalid, rready} = 7'h41;
    {awaddr, araddr, wdata} = 48'h0;
    vsetStrapCode = 4'hd;
    freqStrapCode = 4'he;
    wstrb = 4'hf;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    wait_done();
    $display("test power-up finished");
    for (int i = 0; i < 27; i++) begin
      if (rows[i].w) begin
        axw(rows[i].a, rows[i].d, resp);
        `CHK(resp, rows[i].wr, "write response")
      end
      axr(rows[i].a, rd, resp);
      `CHK(resp, rows[i].rr, "read response")
      `CHK(rd & rows[i].msk, rows[i].exp, "read data")
    end
    wstrb <= 4'h1;
    axw(8'h14, 32'h0000_abcd, resp);
    `CHK(resp, OK, "byte-lane write response")
    wstrb <= 4'hf;
    rdchk(8'h14, FM, 32'h14cd);
    $display("test register table finished");
    win(100);
    `CHK(hi, 50, "master duty cycle")
    `CHK(oe, 100, "master not driving pin")
    `CHK(diff, 0, "sync output not in phase with switching")
    axw(8'h00, 32'(SSC_STANDALONE), resp);
    repeat (3) @(posedge clock);
    win(100);
    `CHK(oe + hi, 0, "standalone drives pin")
    `CHK(rise, 2, "standalone own frequency")
    $display("test master and standalone finished");
    axw(8'h00, 32'(SSC_SLAVE_IN), resp);
    runEn <= 1'b1;
    repeat (100) @(posedge clock);
    rdchk(8'h08, 32'h6, 32'h6);
    win(250);
    `CHK(rise >= 39 && rise <= 41, 1'b1, "in-phase slave frequency")
    `CHK(ph, 0, "in-phase slave edge misaligned")
    axw(8'h00, 32'(SSC_SLAVE_OUT), resp);
    repeat (50) @(posedge clock);
    rdchk(8'h08, 32'h6, 32'h6);
    win(250);
    `CHK(rise >= 39 && rise <= 41, 1'b1, "out-of-phase slave frequency")
    `CHK(ph, rise, "out-of-phase slave edge misaligned")
    runEn <= 1'b0;
    repeat (600) @(posedge clock);
    rdchk(8'h08, 32'h6, 32'h0);
    win(100);
    `CHK(rise, 2, "own timing after clock loss")
    $display("test slave modes finished");
    @(posedge clock);
    vsetStrapCode <= 4'h5;
    freqStrapCode <= 4'h3;
    rst <= 1'b1;
    repeat (3) @(negedge clock);
    `CHK({freqSyncPinOe, strapDone, senseCurrentEn}, 3'b000, "outputs during reset")
    @(posedge clock);
    rst <= 1'b0;
    wait_done();
    rdchk(8'h00, FM, 32'h0100);
    rdchk(8'h04, FM, 32'h0);
    rdchk(8'h08, SM, 32'h0226_0531);
    rdchk(8'h0c, FM, 32'h0266);
    rdchk(8'h10, FM, 32'h0228);
    rdchk(8'h24, FM, 32'h01eb);
    $display("test second reset finished");
    end_sim();
  end
endmodule : tb
